// ---- smc_ctrl.sv ----
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "smc_params.svh"

// Contract
// - Sleep only on halt with enable bit set
// - Codes 000 Idle, 010 Power-down, 110 Standby
// - Mode bits split over three registers
// - Interrupt wake holds core four extra cycles
// - Register file and memory kept across sleep
// - Reset during sleep restarts at reset vector
// - Idle stops core and program clocks only
// - Any enabled interrupt wakes from Idle
// - Power-down stops oscillator and all clocks
// - Deep modes wake on reset or external lines
// - Power-down exit waits fuse-selected start-up
// - Code 110 with crystal enters Standby
// - Standby resumes six cycles after wake
// - Comparator off in all modes except Idle
// - Comparator reference stays on while comparator uses it and is not off
// - Brown-out detector kept on when fused
// - Watchdog kept running when enabled
// - Reference powered only when someone needs it
// - Input buffers off while peripheral clock stops
module smc_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic halt_exec,
	input wire logic irq_pending,
	input wire logic ext_level_irq01,
	input wire logic ext_irq_line_2,
	input wire logic reset_req,
	input wire logic [3:0] clock_source_fuses,
	input wire logic crystal_selected,
	input wire logic brownout_fuse_enable,
	input wire logic wdt_enable,
	input wire logic comparator_off_bit,
	input wire logic comparator_uses_ref,
	output logic core_clock,
	output logic program_memory_clock,
	output logic peripheral_clock,
	output logic main_osc_en,
	output logic comparator_en,
	output logic vref_en,
	output logic bod_en,
	output logic wdt_run_en,
	output logic input_buffer_en,
	output logic wake_buffer_en,
	output logic core_hold,
	output logic mem_write_block,
	output logic sleeping,
	output logic irq_service,
	output logic reset_vector
);

	smc_pkg::smc_ctrl_s s;
	smc_pkg::smc_ctrl_s next_s;
	logic cnt_load;
	logic [4:0] cnt_value;
	logic cnt_done;
	logic sleep_enable_bit;
	logic [2:0] mode_code;
	smc_pkg::smc_mode_e mode;
	logic [4:0] startup;
	logic ext_wake;
	logic comp_needs_ref;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic smc_pkg::smc_mode_e decode_mode(
		input logic [2:0] code,
		input logic crystal
	);
		smc_pkg::smc_mode_e m;
		case (code)
			`SMC_CODE_IDLE: begin
				m = smc_pkg::md_idle;
			end
			`SMC_CODE_PDOWN: begin
				m = smc_pkg::md_pdown;
			end
			`SMC_CODE_STANDBY: begin
				// Without a crystal the oscillator cannot be kept
				// parked, so the deeper mode is used instead
				m = crystal ? smc_pkg::md_standby : smc_pkg::md_pdown;
			end
			default: begin
				m = smc_pkg::md_reserved;
			end
		endcase
		return m;
	endfunction : decode_mode

	function automatic logic [4:0] startup_cycles(input logic [3:0] fuses);
		logic [4:0] c;
		if (fuses >= `SMC_FUSE_RC_LO && fuses <= `SMC_FUSE_RC_HI) begin
			c = `SMC_START_LONG;
		end else begin
			c = `SMC_START_SHORT;
		end
		return c;
	endfunction : startup_cycles

	function automatic logic is_sleep_state(input smc_pkg::smc_state_e st);
		return st == smc_pkg::st_idle || st == smc_pkg::st_pdown ||
			st == smc_pkg::st_standby;
	endfunction : is_sleep_state

	// ----------------------------------------------------------------
	// Mode field gathering
	// ----------------------------------------------------------------
	assign sleep_enable_bit = s.ctrl[`SMC_BIT_SLEEP_EN];
	assign mode_code = {s.cause[`SMC_BIT_MODE_HI],
		s.ctrl[`SMC_BIT_MODE_MID], s.ext[`SMC_BIT_MODE_LO]};
	assign mode = decode_mode(mode_code, crystal_selected);
	assign startup = startup_cycles(clock_source_fuses);
	assign ext_wake = ext_level_irq01 | ext_irq_line_2;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.rdata = `SMC_READ_NONE;
		next_s.irq_service = 1'b0;
		next_s.reset_vector = 1'b0;
		cnt_load = 1'b0;
		cnt_value = `SMC_CNT_ZERO;

		if (reg_write) begin
			case (reg_addr)
				`SMC_OFS_CTRL: begin
					next_s.ctrl = reg_wdata;
				end
				`SMC_OFS_CAUSE: begin
					next_s.cause = reg_wdata;
				end
				`SMC_OFS_EXT: begin
					next_s.ext = reg_wdata;
				end
				default: begin
					next_s.ctrl = s.ctrl;
				end
			endcase
		end

		if (reg_read) begin
			case (reg_addr)
				`SMC_OFS_CTRL: begin
					next_s.rdata = s.ctrl;
				end
				`SMC_OFS_CAUSE: begin
					next_s.rdata = s.cause;
				end
				`SMC_OFS_EXT: begin
					next_s.rdata = s.ext;
				end
				`SMC_OFS_STAT: begin
					next_s.rdata = s.stat;
				end
				default: begin
					next_s.rdata = `SMC_READ_NONE;
				end
			endcase
		end

		case (s.state)
			smc_pkg::st_active: begin
				if (halt_exec && !sleep_enable_bit) begin
					next_s.stat[`SMC_STAT_IGNORED] = 1'b1;
				end
				if (halt_exec && sleep_enable_bit) begin
					next_s.stat[`SMC_STAT_IGNORED] = 1'b0;
					next_s.stat[`SMC_STAT_RESERVED] = 1'b0;
					next_s.stat[`SMC_STAT_SLEPT_HI:`SMC_STAT_SLEPT_LO] =
						mode_code;
					case (mode)
						smc_pkg::md_idle: begin
							next_s.state = smc_pkg::st_idle;
						end
						smc_pkg::md_pdown: begin
							next_s.state = smc_pkg::st_pdown;
						end
						smc_pkg::md_standby: begin
							next_s.state = smc_pkg::st_standby;
						end
						default: begin
							// Reserved code: stay awake, flag it
							next_s.stat[`SMC_STAT_RESERVED] = 1'b1;
						end
					endcase
				end
			end
			smc_pkg::st_idle: begin
				if (reset_req) begin
					next_s.state = smc_pkg::st_wake;
					next_s.wake_reset = 1'b1;
					cnt_load = 1'b1;
					cnt_value = startup;
				end else if (irq_pending) begin
					next_s.state = smc_pkg::st_wake;
					next_s.wake_reset = 1'b0;
					cnt_load = 1'b1;
					cnt_value = `SMC_WAKE_EXTRA;
				end
			end
			smc_pkg::st_pdown: begin
				if (reset_req) begin
					next_s.state = smc_pkg::st_wake;
					next_s.wake_reset = 1'b1;
					cnt_load = 1'b1;
					cnt_value = startup;
				end else if (ext_wake) begin
					next_s.state = smc_pkg::st_wake;
					next_s.wake_reset = 1'b0;
					cnt_load = 1'b1;
					cnt_value = 5'(startup + `SMC_WAKE_EXTRA);
				end
			end
			smc_pkg::st_standby: begin
				if (reset_req) begin
					next_s.state = smc_pkg::st_wake;
					next_s.wake_reset = 1'b1;
					cnt_load = 1'b1;
					cnt_value = `SMC_STANDBY_CYC;
				end else if (ext_wake) begin
					next_s.state = smc_pkg::st_wake;
					next_s.wake_reset = 1'b0;
					cnt_load = 1'b1;
					cnt_value = 5'(`SMC_STANDBY_CYC + `SMC_WAKE_EXTRA);
				end
			end
			smc_pkg::st_wake: begin
				// A reset arriving mid-wake overrides the interrupt
				if (reset_req) begin
					next_s.wake_reset = 1'b1;
				end
				if (cnt_done) begin
					next_s.state = smc_pkg::st_active;
					next_s.stat[`SMC_STAT_RESET] =
						s.wake_reset | reset_req;
					if (s.wake_reset || reset_req) begin
						next_s.reset_vector = 1'b1;
					end else begin
						next_s.irq_service = 1'b1;
					end
				end
			end
			default: begin
				next_s.state = smc_pkg::st_active;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s.state <= smc_pkg::st_active;
			s.ctrl <= `SMC_RST_CTRL;
			s.cause <= `SMC_RST_CAUSE;
			s.ext <= `SMC_RST_EXT;
			s.stat <= `SMC_RST_STAT;
			s.rdata <= `SMC_READ_NONE;
			s.wake_reset <= 1'b0;
			s.irq_service <= 1'b0;
			s.reset_vector <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Wake-up delay
	// ----------------------------------------------------------------
	smc_delay u_delay (
		.clock(clock),
		.rst(rst),
		.load(cnt_load),
		.load_value(cnt_value),
		.done(cnt_done)
	);

	// ----------------------------------------------------------------
	// Clock domains and analog enables
	// ----------------------------------------------------------------
	always_comb begin
		core_clock = 1'b0;
		program_memory_clock = 1'b0;
		peripheral_clock = 1'b0;
		main_osc_en = 1'b1;
		case (s.state)
			smc_pkg::st_active: begin
				core_clock = 1'b1;
				program_memory_clock = 1'b1;
				peripheral_clock = 1'b1;
			end
			smc_pkg::st_idle: begin
				// Timers, serial units and interrupt logic keep running
				peripheral_clock = 1'b1;
			end
			smc_pkg::st_pdown: begin
				// Only the asynchronous wake logic, fused brown-out detector, enabled watchdog and needed reference stay alive
				main_osc_en = 1'b0;
			end
			smc_pkg::st_standby: begin
				// Oscillator kept running buys the short restart
				main_osc_en = 1'b1;
			end
			smc_pkg::st_wake: begin
				// Core stays gated through the whole wake delay, so
				// nothing executes before the oscillator is stable
				peripheral_clock = 1'b1;
			end
			default: begin
				main_osc_en = 1'b1;
			end
		endcase
	end

	// The comparator follows the peripheral clock, so every deeper
	// mode turns it off without software; its reference may stay up
	assign comparator_en = !comparator_off_bit &&
		peripheral_clock;
	// Reference held in sleep while the comparator is on and set to use it
	assign comp_needs_ref = comparator_uses_ref && !comparator_off_bit;
	assign bod_en = brownout_fuse_enable;
	assign wdt_run_en = wdt_enable;
	assign vref_en = bod_en || comp_needs_ref;
	assign input_buffer_en = peripheral_clock;
	// External wake lines must stay visible in every state
	assign wake_buffer_en = 1'b1;
	assign core_hold = (s.state != smc_pkg::st_active);
	// Writes to register file and memory blocked while asleep
	assign mem_write_block = (s.state != smc_pkg::st_active);
	assign sleeping = is_sleep_state(s.state);
	assign irq_service = s.irq_service;
	assign reset_vector = s.reset_vector;
	assign reg_rdata = s.rdata;

endmodule : smc_ctrl

// ---- smc_params.svh ----
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SMC_ADDR_W 2
`define SMC_OFS_CTRL 2'h0
`define SMC_OFS_CAUSE 2'h1
`define SMC_OFS_EXT 2'h2
`define SMC_OFS_STAT 2'h3

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SMC_BIT_SLEEP_EN 5
`define SMC_BIT_MODE_MID 4
`define SMC_BIT_MODE_HI 5
`define SMC_BIT_MODE_LO 7
`define SMC_STAT_SLEPT_LO 0
`define SMC_STAT_SLEPT_HI 2
`define SMC_STAT_RESET 3
`define SMC_STAT_IGNORED 4
`define SMC_STAT_RESERVED 5
`define SMC_RST_CTRL 8'h00
`define SMC_RST_CAUSE 8'h00
`define SMC_RST_EXT 8'h00
`define SMC_RST_STAT 8'h00
`define SMC_READ_NONE 8'h00

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define SMC_CODE_IDLE 3'h0
`define SMC_CODE_PDOWN 3'h2
`define SMC_CODE_STANDBY 3'h6

// ----------------------------------------------------------------
// Timing counts in clock cycles
// ----------------------------------------------------------------
`define SMC_CNT_W 5
`define SMC_CNT_ZERO 5'h00
`define SMC_CNT_ONE 5'h01
`define SMC_WAKE_EXTRA 5'h04
`define SMC_STANDBY_CYC 5'h06
`define SMC_START_SHORT 5'h06
`define SMC_START_LONG 5'h12
`define SMC_FUSE_RC_LO 4'h5
`define SMC_FUSE_RC_HI 4'h8

`endif

// ---- smc_pkg.sv ----
package smc_pkg;

	typedef enum logic [2:0] {
		st_active,
		st_idle,
		st_pdown,
		st_standby,
		st_wake
	} smc_state_e;

	typedef enum logic [1:0] {
		md_idle,
		md_pdown,
		md_standby,
		md_reserved
	} smc_mode_e;

	typedef struct packed {
		logic [4:0] count;
		logic done;
	} smc_delay_s;

	typedef struct packed {
		smc_state_e state;
		logic [7:0] ctrl;
		logic [7:0] cause;
		logic [7:0] ext;
		logic [7:0] stat;
		logic [7:0] rdata;
		logic wake_reset;
		logic irq_service;
		logic reset_vector;
	} smc_ctrl_s;

endpackage : smc_pkg

// ---- smc_delay.sv ----
`timescale 1ns/1ps
`include "smc_params.svh"

module smc_delay (
	input wire logic clock,
	input wire logic rst,
	input wire logic load,
	input wire logic [4:0] load_value,
	output logic done
);

	smc_pkg::smc_delay_s s;
	smc_pkg::smc_delay_s next_s;

	// ----------------------------------------------------------------
	// Down counter; done pulses exactly load_value cycles after load
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (load) begin
			next_s.count = load_value;
		end else if (s.count != `SMC_CNT_ZERO) begin
			next_s.count = s.count - `SMC_CNT_ONE;
			next_s.done = (s.count == `SMC_CNT_ONE);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;

endmodule : smc_delay

// ---- smc_ctrl_monitor.sv ----
`timescale 1ns/1ps
module smc_ctrl_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic irq_pending,
	input wire logic ext_level_irq01,
	input wire logic ext_irq_line_2,
	input wire logic reset_req,
	input wire logic brownout_fuse_enable,
	input wire logic wdt_enable,
	input wire logic comparator_off_bit,
	input wire logic comparator_uses_ref,
	input wire logic core_clock,
	input wire logic program_memory_clock,
	input wire logic peripheral_clock,
	input wire logic main_osc_en,
	input wire logic comparator_en,
	input wire logic vref_en,
	input wire logic bod_en,
	input wire logic wdt_run_en,
	input wire logic input_buffer_en,
	input wire logic wake_buffer_en,
	input wire logic core_hold,
	input wire logic mem_write_block,
	input wire logic sleeping,
	input wire logic irq_service,
	input wire logic reset_vector
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// ----
	// Wake timing
	// ----
	// Hold lasts the delay count plus the edge that returns to active
	sequence hold_idle;
		core_hold[*5];
	endsequence
	sequence hold_standby;
		core_hold[*7];
	endsequence
	chk_idle_wake:
	assert property (sleeping && peripheral_clock && irq_pending && !reset_req
		|=> hold_idle ##1 (irq_service && !core_hold))
		else $error("idle wake");
	chk_standby_reset:
	assert property (sleeping && main_osc_en && !peripheral_clock && reset_req
		|=> hold_standby ##1 reset_vector) else $error("standby wake");
	chk_deep_ignore:
	assert property (sleeping && !peripheral_clock && !reset_req
		&& !ext_level_irq01 && !ext_irq_line_2 |=> sleeping)
		else $error("deep wake source");
	// ----
	// Domains and enables
	// ----
	chk_idle_clocks:
	assert property (sleeping |-> !core_clock && !program_memory_clock)
		else $error("core clocks in sleep");
	chk_pdown_clocks:
	assert property (!main_osc_en |-> sleeping && !peripheral_clock)
		else $error("osc off while awake");
	chk_comp_deep:
	assert property (sleeping && !peripheral_clock |-> !comparator_en)
		else $error("comp");
	chk_vref_need:
	assert property (vref_en == (bod_en || (comparator_uses_ref
		&& !comparator_off_bit))) else $error("vref");
	chk_fuse_keep:
	assert property (bod_en == brownout_fuse_enable
		&& wdt_run_en == wdt_enable) else $error("bod or wdt");
	chk_input_bufs:
	assert property (input_buffer_en == peripheral_clock && wake_buffer_en)
		else $error("buffers");
	chk_mem_frozen:
	assert property (mem_write_block == core_hold) else $error("mem");
endmodule : smc_ctrl_monitor

bind smc_ctrl smc_ctrl_monitor u_mon (.clock, .rst, .irq_pending,
	.ext_level_irq01, .ext_irq_line_2, .reset_req, .brownout_fuse_enable,
	.wdt_enable, .comparator_off_bit, .comparator_uses_ref, .core_clock,
	.program_memory_clock, .peripheral_clock, .main_osc_en, .comparator_en,
	.vref_en, .bod_en, .wdt_run_en, .input_buffer_en, .wake_buffer_en,
	.core_hold, .mem_write_block, .sleeping, .irq_service, .reset_vector);

// ---- smc_core.sv ----
`timescale 1ns/1ps
module smc_core (
	input wire logic clock,
	input wire logic rst,
	input wire logic req,
	input wire logic [2:0] sel,
	input wire logic irq_service,
	input wire logic reset_vector,
	output logic halt_exec,
	output logic irq_pending,
	output logic ext_level_irq01,
	output logic ext_irq_line_2,
	output logic reset_req
);
	// ----
	// Core and interrupt side
	// ----
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			{halt_exec, reset_req, ext_irq_line_2, ext_level_irq01,
				irq_pending} <= 5'h00;
		else if (req)
			{halt_exec, reset_req, ext_irq_line_2, ext_level_irq01,
				irq_pending} <= 5'h01 << sel;
		else if (irq_service || reset_vector)
			{halt_exec, reset_req, ext_irq_line_2, ext_level_irq01,
				irq_pending} <= 5'h00;
		else
			halt_exec <= 1'b0;
	end
endmodule : smc_core

// ---- smc_ctrl_test.sv ----
`timescale 1ns/1ps
module smc_ctrl_test;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic halt_exec, irq_pending, ext_level_irq01, ext_irq_line_2, reset_req;
	logic [3:0] clock_source_fuses = 4'h1;
	// Crystal, brown-out, watchdog, comparator off, comparator reference
	logic [4:0] misc = 5'h10;
	logic core_clock, program_memory_clock, peripheral_clock, main_osc_en;
	logic comparator_en, vref_en, bod_en, wdt_run_en, input_buffer_en;
	logic wake_buffer_en, core_hold, mem_write_block;
	logic sleeping, irq_service, reset_vector;
	logic req = 1'b0;
	logic [2:0] sel = 3'h0;
	int failures = 0;
	int n_checks = 0;

	always #10 clock = ~clock;

	smc_ctrl DUT (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .halt_exec, .irq_pending, .ext_level_irq01,
		.ext_irq_line_2, .reset_req, .clock_source_fuses,
		.crystal_selected(misc[4]), .brownout_fuse_enable(misc[3]),
		.wdt_enable(misc[2]), .comparator_off_bit(misc[1]),
		.comparator_uses_ref(misc[0]), .core_clock, .program_memory_clock,
		.peripheral_clock, .main_osc_en, .comparator_en, .vref_en, .bod_en,
		.wdt_run_en, .input_buffer_en, .wake_buffer_en, .core_hold,
		.mem_write_block, .sleeping, .irq_service, .reset_vector);

	smc_core u_core (.clock, .rst, .req, .sel, .irq_service, .reset_vector,
		.halt_exec, .irq_pending, .ext_level_irq01, .ext_irq_line_2,
		.reset_req);

	// ----
	// Shared tasks
	// ----
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	task rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		v = reg_rdata;
	endtask : rd

	// Sel 0 irq, 1 lines 0/1, 2 line 2, 3 reset, 4 halt
	task pk(input logic [2:0] s);
		@(posedge clock);
		sel <= s;
		req <= 1'b1;
		@(posedge clock);
		req <= 1'b0;
	endtask : pk

	task md(input logic [2:0] c, input logic en);
		wr(2'h1, {2'h0, c[2], 5'h00});
		wr(2'h2, {c[0], 7'h00});
		wr(2'h0, {2'h0, en, c[1], 4'h0});
	endtask : md

	task test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// ----
	// Scenarios
	// ----
	task t_regs();
		logic [7:0] r;
		for (int i = 0; i < 4; i++) begin
			rd(i[1:0], r);
			chk("reset_val", r, 8'h00);
		end
		wr(2'h2, 8'hA5);
		rd(2'h2, r);
		chk("ext_rw", r, 8'hA5);
		wr(2'h3, 8'hFF);
		rd(2'h3, r);
		chk("stat_ro", r, 8'h00);
		wr(2'h2, 8'h00);
		$display("registers done");
	endtask : t_regs

	task t_ref();
		logic [7:0] r;
		md(3'h0, 1'b0);
		pk(3'h4);
		repeat (2) @(negedge clock);
		chk("no_enable", sleeping, 8'h00);
		rd(2'h3, r);
		chk("ignored", r[4], 8'h01);
		for (int i = 1; i < 8; i++) begin
			if (i != 2 && i != 6) begin
				md(i[2:0], 1'b1);
				pk(3'h4);
				repeat (2) @(negedge clock);
				chk("reserved", sleeping, 8'h00);
				rd(2'h3, r);
				chk("res_flag", r[5], 8'h01);
			end
		end
		md(3'h0, 1'b0);
		$display("refusals done");
	endtask : t_ref

	task sl(input logic [2:0] c, input logic [2:0] s, input logic [3:0] f,
		input logic [4:0] m, input logic [7:0] n, input logic v);
		logic [7:0] k;
		logic [7:0] r;
		logic dp;
		@(posedge clock);
		misc <= m;
		clock_source_fuses <= f;
		md(c, 1'b1);
		pk(3'h4);
		repeat (2) @(negedge clock);
		dp = (c != 3'h0);
		chk("asleep", sleeping, 8'h01);
		chk("osc", main_osc_en, !dp || (c[2] && m[4]));
		chk("io_clk", peripheral_clock, !dp);
		chk("comp", comparator_en, !dp && !m[1]);
		chk("vref", vref_en, m[3] || (m[0] && !m[1]));
		if (dp) begin
			pk(3'h0);
			repeat (3) @(negedge clock);
			chk("deep_irq", sleeping, 8'h01);
		end
		pk(s);
		k = 8'h00;
		do begin
			@(negedge clock);
			k++;
		end while (!(irq_service || reset_vector) && k < 8'h28);
		chk("wake_cyc", k, n);
		chk("to_vector", reset_vector, v);
		rd(2'h3, r);
		chk("wake_cause", r[3], v);
		wr(2'h0, 8'h00);
		$display("sleep %h done", c);
	endtask : sl

	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_ref();
		sl(3'h0, 3'h0, 4'h1, 5'h00, 8'h07, 1'b0);
		// Comparator switched off by software before Idle
		sl(3'h0, 3'h3, 4'h1, 5'h0B, 8'h09, 1'b1);
		sl(3'h2, 3'h1, 4'h9, 5'h15, 8'h0D, 1'b0);
		sl(3'h2, 3'h2, 4'h5, 5'h01, 8'h19, 1'b0);
		sl(3'h2, 3'h3, 4'h8, 5'h06, 8'h15, 1'b1);
		sl(3'h6, 3'h3, 4'h1, 5'h1F, 8'h09, 1'b1);
		sl(3'h6, 3'h2, 4'h1, 5'h10, 8'h0D, 1'b0);
		sl(3'h6, 3'h1, 4'h1, 5'h00, 8'h0D, 1'b0);
		test_done();
	end

	initial begin
		#60000;
		failures++;
		test_done();
	end
endmodule : smc_ctrl_test
